// file: design/drm_pkg.sv
// Purpose: shared constants and types for the loop mode control
// Assumes: 8-bit register port, byte-wide registers
// Notes: register offsets are byte addresses on the plain port
package drm_pkg;
	// sizes
	localparam int NREF = 9;
	localparam int REF_W = 4;
	localparam int PRIO_W = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int STRAP_W = 2;
	// register offsets
	localparam logic [7:0] ADDR_MODE = 8'h1F;
	localparam logic [7:0] ADDR_REFSEL = 8'h20;
	localparam logic [7:0] ADDR_MASK = 8'h21;
	// reset values
	localparam logic [7:0] MASK_RST = 8'h3C;
	localparam logic [3:0] REFSEL_RST = 4'h0;
	localparam logic [7:0] DATA_ZERO = 8'h00;
	// field positions
	localparam int MODE_MSB = 2;
	localparam int REFSEL_MSB = 3;
	localparam int SWMASK_MSB = 3;
	localparam int FAIL_CYCLE = 0;
	localparam int FAIL_COARSE = 1;
	localparam int FAIL_GUARD = 2;
	localparam int FAIL_PRECISE = 3;
	localparam logic [4:0] MODE_PAD = 5'h00;
	localparam logic [3:0] REFSEL_PAD = 4'h0;
	// loop modes
	typedef enum logic [2:0] {
		MODE_MAN_NORMAL = 3'b000,
		MODE_MAN_HOLD = 3'b001,
		MODE_MAN_FREE = 3'b010,
		MODE_AUTO = 3'b011,
		MODE_STEER = 3'b100
	} drm_mode_type;
	// loop condition shown to the core
	typedef enum logic [1:0] {
		LOOP_FREE = 2'b00,
		LOOP_LOCKED = 2'b01,
		LOOP_HOLD = 2'b10,
		LOOP_STEER = 2'b11
	} drm_loop_type;
	// all state of the block except the two reset release flops
	typedef struct packed {
		logic strap_done;
		drm_mode_type mode;
		logic [3:0] refsel;
		logic [7:0] mask;
		logic [7:0] rd_data;
		logic [3:0] active_ref;
		drm_loop_type loop_state;
		logic switch_evt;
		logic steer_en;
	} drm_state_type;
endpackage : drm_pkg

// file: design/drm_top.sv
// Purpose: mode and reference selection for the first loop
// Assumes: inputs synchronous to clk, indicators high on failure
// Notes: priority codes arrive as a port, lower code ranks higher
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
//Contract
// (RULE1) manual normal: lock selected, hold on failure
// (RULE2) manual holdover: no switching, always holdover
// (RULE3) manual free-run: no switching, always free-run
// (RULE4) automatic: lock best qualified reference
// (RULE5) active fails: switch to next qualified
// (RULE6) no qualified reference: enter holdover
// (RULE7) steer mode: software drives the oscillator
// (RULE8) steer mode only by register write
// (RULE9) mode default from strap pins
// (RULE10) software writes mode upper bits zero
// (RULE11) select register read-only in automatic
// (RULE12) manual normal uses written select value
// (RULE13) select codes 0..8, rest reserved
// (RULE14) mask bits: cycle, coarse, guard, precise
// (RULE15) mask zero ignores indicator, one counts
// (RULE16) priority code zero ranks highest
// (RULE17) automatic ignores writes to select
module drm_top #(
	parameter int NREF = drm_pkg::NREF
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [drm_pkg::ADDR_W-1:0] addr,
	input wire logic [drm_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [drm_pkg::DATA_W-1:0] rd_data,
	input wire logic [drm_pkg::STRAP_W-1:0] loop_mode_strap_pins,
	input wire logic [NREF-1:0] cycle_monitor_failure,
	input wire logic [NREF-1:0] coarse_frequency_failure,
	input wire logic [NREF-1:0] guard_timer_failure,
	input wire logic [NREF-1:0] precise_frequency_failure,
	input wire logic [NREF*drm_pkg::PRIO_W-1:0] ref_priority,
	output logic [drm_pkg::REF_W-1:0] active_ref,
	output logic [1:0] loop_state,
	output logic switch_pulse,
	output logic controlled_oscillator_steer
);
	import drm_pkg::*;

	// elaboration check on the reference count
	if (NREF < 1 || NREF > (1 << REF_W))
	begin : g_bad_nref
		$error("NREF does not fit the select field");
	end

	drm_state_type s_q;
	drm_state_type s_d;
	logic rst_meta_q;
	logic rst_n_q;
	logic [NREF-1:0] qual;
	logic any_qual;
	logic [REF_W-1:0] best_idx;
	logic [PRIO_W-1:0] best_prio;
	logic sel_ok;

	// true when reference r exists and is qualified
	function automatic logic ref_ok(
		input logic [REF_W-1:0] r,
		input logic [NREF-1:0] qv
	);
		logic ok;
		ok = 1'b0;
		for (int i = 0; i < NREF; i++)
		begin
			if (REF_W'(i) == r)
				ok = qv[i]; // RULE13
		end
		return ok;
	endfunction : ref_ok

	// reset release through two flops
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// per reference qualification, unmasked indicators only
	for (genvar g = 0; g < NREF; g++)
	begin : g_qual
		logic [3:0] fails;
		assign fails[FAIL_CYCLE] = cycle_monitor_failure[g]; // RULE14
		assign fails[FAIL_COARSE] = coarse_frequency_failure[g]; // RULE14
		assign fails[FAIL_GUARD] = guard_timer_failure[g]; // RULE14
		assign fails[FAIL_PRECISE] = precise_frequency_failure[g]; // RULE14
		assign qual[g] = ~|(fails & s_q.mask[SWMASK_MSB:0]); // RULE15
	end

	// best qualified reference, lowest code wins, ties to lower index
	always_comb
	begin
		logic [PRIO_W-1:0] p;
		p = '0;
		any_qual = 1'b0;
		best_idx = '0;
		best_prio = '1;
		for (int i = 0; i < NREF; i++)
		begin
			p = ref_priority[i*PRIO_W +: PRIO_W];
			if (qual[i] && (!any_qual || p < best_prio)) // RULE16
			begin
				any_qual = 1'b1;
				best_idx = REF_W'(i);
				best_prio = p;
			end
		end
	end

	assign sel_ok = ref_ok(s_q.refsel, qual);

	// next state: registers, reads and loop control
	always_comb
	begin
		s_d = s_q;
		s_d.switch_evt = 1'b0;
		s_d.rd_data = DATA_ZERO;
		// strap load once after release, never the steer mode
		if (!s_q.strap_done)
		begin
			s_d.strap_done = 1'b1;
			s_d.mode = drm_mode_type'({1'b0, loop_mode_strap_pins}); // RULE9 RULE8
		end
		else if (wr_en && addr == ADDR_MODE && wr_data[MODE_MSB:0] <= MODE_STEER)
			s_d.mode = drm_mode_type'(wr_data[MODE_MSB:0]); // RULE8
		// select is writable except in automatic mode
		if (wr_en && addr == ADDR_REFSEL && s_q.mode != MODE_AUTO) // RULE17
			s_d.refsel = wr_data[REFSEL_MSB:0]; // RULE12
		if (wr_en && addr == ADDR_MASK)
			s_d.mask = wr_data;
		// read port, unmapped reads give zero
		if (rd_en)
		begin
			case (addr)
				ADDR_MODE: s_d.rd_data = {MODE_PAD, s_q.mode}; // RULE10
				ADDR_REFSEL:
				begin
					if (s_q.mode == MODE_AUTO)
						s_d.rd_data = {REFSEL_PAD, s_q.active_ref}; // RULE11
					else
						s_d.rd_data = {REFSEL_PAD, s_q.refsel};
				end
				ADDR_MASK: s_d.rd_data = s_q.mask;
				default: s_d.rd_data = DATA_ZERO;
			endcase
		end
		// loop control per mode
		s_d.steer_en = 1'b0;
		s_d.loop_state = LOOP_FREE;
		if (s_q.strap_done)
		begin
			unique case (s_q.mode)
				MODE_MAN_NORMAL:
				begin
					s_d.active_ref = s_q.refsel; // RULE12
					s_d.loop_state = sel_ok ? LOOP_LOCKED : LOOP_HOLD; // RULE1
				end
				MODE_MAN_HOLD: s_d.loop_state = LOOP_HOLD; // RULE2
				MODE_MAN_FREE: s_d.loop_state = LOOP_FREE; // RULE3
				MODE_AUTO:
				begin
					if (any_qual)
					begin
						s_d.active_ref = best_idx; // RULE4 RULE5
						s_d.loop_state = LOOP_LOCKED;
					end
					else
						s_d.loop_state = LOOP_HOLD; // RULE6
				end
				MODE_STEER:
				begin
					s_d.steer_en = 1'b1; // RULE7
					s_d.loop_state = LOOP_STEER;
				end
			endcase
		end
		// one-cycle pulse when the active reference moves
		s_d.switch_evt = (s_d.active_ref != s_q.active_ref);
	end

	// state register
	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			s_q.strap_done <= 1'b0;
			s_q.mode <= MODE_MAN_FREE;
			s_q.refsel <= REFSEL_RST;
			s_q.mask <= MASK_RST;
			s_q.rd_data <= DATA_ZERO;
			s_q.active_ref <= REFSEL_RST;
			s_q.loop_state <= LOOP_FREE;
			s_q.switch_evt <= 1'b0;
			s_q.steer_en <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	// outputs straight from the state flops
	assign rd_data = s_q.rd_data;
	assign active_ref = s_q.active_ref;
	assign loop_state = s_q.loop_state;
	assign switch_pulse = s_q.switch_evt;
	assign controlled_oscillator_steer = s_q.steer_en;

	// checks on the mode behaviour
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n_q);

	property p_man_lock;
		s_q.strap_done && s_q.mode == MODE_MAN_NORMAL && sel_ok
		|=> loop_state == LOOP_LOCKED && active_ref == $past(s_q.refsel);
	endproperty
	a_man_lock: assert property (p_man_lock) // RULE1
		else $error("manual normal did not lock the selected reference");

	property p_man_fail;
		s_q.strap_done && s_q.mode == MODE_MAN_NORMAL && !sel_ok
		|=> loop_state == LOOP_HOLD;
	endproperty
	a_man_fail: assert property (p_man_fail) // RULE1
		else $error("manual normal did not hold on failure");

	property p_hold;
		s_q.strap_done && s_q.mode == MODE_MAN_HOLD |=> loop_state == LOOP_HOLD;
	endproperty
	a_hold: assert property (p_hold) // RULE2
		else $error("manual holdover left holdover");

	property p_free;
		s_q.strap_done && s_q.mode == MODE_MAN_FREE |=> loop_state == LOOP_FREE;
	endproperty
	a_free: assert property (p_free) // RULE3
		else $error("manual free-run left free-run");

	property p_auto_best;
		s_q.strap_done && s_q.mode == MODE_AUTO && any_qual
		|=> loop_state == LOOP_LOCKED && active_ref == $past(best_idx);
	endproperty
	a_auto_best: assert property (p_auto_best) // RULE4
		else $error("automatic mode missed the best reference");

	property p_auto_none;
		s_q.strap_done && s_q.mode == MODE_AUTO && !any_qual
		|=> loop_state == LOOP_HOLD && $stable(active_ref);
	endproperty
	a_auto_none: assert property (p_auto_none) // RULE6
		else $error("automatic mode did not hold without references");

	property p_steer;
		s_q.strap_done && s_q.mode == MODE_STEER
		|=> controlled_oscillator_steer && loop_state == LOOP_STEER;
	endproperty
	a_steer: assert property (p_steer) // RULE7
		else $error("steer mode not shown");

	property p_strap;
		!s_q.strap_done
		|=> s_q.mode == {1'b0, $past(loop_mode_strap_pins)} && s_q.mode != MODE_STEER;
	endproperty
	a_strap: assert property (p_strap) // RULE9
		else $error("mode default not taken from straps");

	property p_ro;
		wr_en && addr == ADDR_REFSEL && s_q.mode == MODE_AUTO
		|=> s_q.refsel == $past(s_q.refsel);
	endproperty
	a_ro: assert property (p_ro) // RULE17
		else $error("select written in automatic mode");

	property p_rd_sel;
		rd_en && addr == ADDR_REFSEL && s_q.mode == MODE_AUTO
		|=> rd_data == {REFSEL_PAD, $past(s_q.active_ref)};
	endproperty
	a_rd_sel: assert property (p_rd_sel) // RULE11
		else $error("select read did not show the chosen reference");

	property p_unmasked;
		s_q.strap_done && s_q.mode == MODE_AUTO && s_q.mask[SWMASK_MSB:0] == 4'h0
		|=> loop_state == LOOP_LOCKED;
	endproperty
	a_unmasked: assert property (p_unmasked) // RULE15
		else $error("masked indicators still disqualified");
endmodule : drm_top

// file: tb/drm_top_test.sv
// Purpose: self-checking bench for the loop mode and reference select control
// Assumes: straps load 001 at start, ref5 then ref2 rank best in automatic mode
// Notes: loop outputs are judged three edges after each cause settles
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin mismatches++; \
	$display("[ERR] %s exp %h got %h", nm, ex, got); end end
module drm_top_test;
	import drm_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] rd_data;
	logic [1:0] straps = 2'b01;
	logic [8:0] cyc_f = 9'h000;
	logic [8:0] crs_f = 9'h000;
	logic [8:0] grd_f = 9'h000;
	logic [8:0] prc_f = 9'h000;
	logic [35:0] prio = {9{4'hF}};
	logic [3:0] active_ref;
	logic [1:0] loop_state;
	logic switch_pulse;
	logic steer;
	int mismatches = 0;
	int checks_done = 0;
	// 100 ns clock
	always #50 clk = ~clk;
	drm_top #(.NREF(9)) u_drm_top (.clk(clk), .resetn(resetn), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.loop_mode_strap_pins(straps), .cycle_monitor_failure(cyc_f),
		.coarse_frequency_failure(crs_f), .guard_timer_failure(grd_f),
		.precise_frequency_failure(prc_f), .ref_priority(prio), .active_ref(active_ref),
		.loop_state(loop_state), .switch_pulse(switch_pulse),
		.controlled_oscillator_steer(steer));
	// one-cycle write strobe
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr
	// read strobe, data judged in the following cycle
	task rd(input logic [7:0] a, input logic [7:0] ex);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		`CHK("rd_data", ex, rd_data)
	endtask : rd
	// let a cause reach the registered loop outputs
	task settle;
		repeat (3) @(posedge clk);
		#1;
	endtask : settle
	// drive one failure indicator group
	task set_fail(input int k, input logic [8:0] v);
		@(posedge clk);
		case (k)
			0: cyc_f <= v;
			1: crs_f <= v;
			2: grd_f <= v;
			default: prc_f <= v;
		endcase
	endtask : set_fail
	// strap default, reset values, unmapped read
	task t_strap;
		rd(8'h1F, 8'h01);
		rd(8'h21, 8'h3C);
		rd(8'h20, 8'h00);
		rd(8'h40, 8'h00);
		settle;
		`CHK("loop_state", 2'b10, loop_state)
		$display("done: strap");
	endtask : t_strap
	// manual hold, free-run and steer modes, refused mode code
	task t_modes;
		logic [7:0] m [3];
		logic [1:0] ls [3];
		m = '{8'h01, 8'h02, 8'h04};
		ls = '{2'b10, 2'b00, 2'b11};
		for (int i = 0; i < 3; i++)
		begin
			wr(8'h1F, m[i]);
			settle;
			`CHK("loop_state", ls[i], loop_state)
			`CHK("steer", (i == 2), steer)
		end
		wr(8'h1F, 8'h05);
		rd(8'h1F, 8'h04);
		$display("done: modes");
	endtask : t_modes
	// manual normal selection, masking and reserved codes
	task t_manual;
		wr(8'h1F, 8'h00);
		wr(8'h20, 8'h03);
		set_fail(0, 9'h008);
		settle;
		`CHK("active_ref", 4'h3, active_ref)
		`CHK("loop_state", 2'b01, loop_state)
		set_fail(0, 9'h000);
		wr(8'h21, 8'h0F);
		for (int k = 0; k < 4; k++)
		begin
			set_fail(k, 9'h008);
			settle;
			`CHK("loop_state", 2'b10, loop_state)
			set_fail(k, 9'h000);
			settle;
			`CHK("loop_state", 2'b01, loop_state)
		end
		wr(8'h20, 8'h09);
		settle;
		`CHK("loop_state", 2'b10, loop_state)
		wr(8'h20, 8'h08);
		settle;
		`CHK("active_ref", 4'h8, active_ref)
		$display("done: manual");
	endtask : t_manual
	// automatic ranking, read-only select, switchover and holdover
	task t_auto;
		int n;
		n = 0;
		@(posedge clk);
		prio <= {12'hFFF, 4'h0, 8'hFF, 4'h1, 8'hFF};
		wr(8'h1F, 8'h03);
		settle;
		`CHK("active_ref", 4'h5, active_ref)
		`CHK("loop_state", 2'b01, loop_state)
		rd(8'h20, 8'h05);
		wr(8'h20, 8'h01);
		rd(8'h20, 8'h05);
		set_fail(2, 9'h020);
		repeat (4)
		begin
			@(posedge clk);
			#1;
			if (switch_pulse === 1'b1)
				n++;
		end
		`CHK("active_ref", 4'h2, active_ref)
		`CHK("pulses", 1, n)
		set_fail(2, 9'h1FF);
		settle;
		`CHK("loop_state", 2'b10, loop_state)
		// all indicators masked: every reference qualifies again
		wr(8'h21, 8'h00);
		settle;
		`CHK("active_ref", 4'h5, active_ref)
		`CHK("loop_state", 2'b01, loop_state)
		$display("done: auto");
	endtask : t_auto
	// mid-run reset with other straps, reset values and strap default again
	task t_reset;
		@(posedge clk);
		straps <= 2'b11;
		resetn <= 1'b0;
		@(posedge clk);
		#1;
		`CHK("loop_state", 2'b00, loop_state)
		`CHK("active_ref", 4'h0, active_ref)
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (5) @(posedge clk);
		rd(8'h1F, 8'h03);
		rd(8'h21, 8'h3C);
		rd(8'h20, 8'h00);
		settle;
		`CHK("loop_state", 2'b10, loop_state)
		$display("done: reset");
	endtask : t_reset
	// counts and verdict
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	// watchdog far beyond the expected run of about 135 cycles
	initial
	begin
		#2000000;
		mismatches++;
		summarize;
	end
	// main sequence
	initial
	begin
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		repeat (5) @(posedge clk);
		t_strap;
		t_modes;
		t_manual;
		t_auto;
		t_reset;
		summarize;
	end
endmodule : drm_top_test
